// [hdl/azc_pkg.sv]
/*
 Package for the auto-zero offset trim controller: port addresses, control word,
 switch codes and timing counts shared by the controller and its port sequencer.
 Assumes a peripheral port bank reached by an 8-bit address, 8-bit data bus with
 read and write strobes, and a converter whose done line is active low.
*/
// Behaviour
// RL1 - Converter returns all zeros when the negative input is at or above the positive.
// RL2 - Clear the trial bit when the result reads zero, keep it when nonzero.
// RL3 - Run exactly eight approximation steps, then hold the final trim code.
// RL4 - Zero switch closed while zeroing; afterwards it opens and signal switch closes.
// RL5 - Invert data read from the converter and data written to trim and switches.
// RL6 - Result read at E4, trim written at E5, switches written at E6.
// RL7 - Port configuration goes through the control word location at E7.
// RL8 - Basic mode 0: result port input, trim and switch ports outputs.
// RL9 - On completion acknowledge the processor branches to the handler at 3C3D.
// RL10 - A one on a trim bit raises the trim node, pushing the output negative.
// RL11 - Trim port acts as the approximation register driving a binary resistor DAC.
// RL12 - Per measurement: start conversion, wait for completion, then read the result.
// RL13 - Trial bits go from the top bit down, each set before its conversion starts.
// RL14 - Before searching, set switches to zeroing state and clear the trim code.
package azc_pkg;
    localparam logic [7:0]  ADDR_RESULT  = 8'hE4;
    localparam logic [7:0]  ADDR_TRIM    = 8'hE5;
    localparam logic [7:0]  ADDR_SWITCH  = 8'hE6;
    localparam logic [7:0]  ADDR_CTRL    = 8'hE7;
    // Mode set flag, mode 0, port A in, ports B and C out.
    localparam logic [7:0]  CTRL_WORD    = 8'h90;
    localparam logic [15:0] HANDLER_ADDR = 16'h3C3D;
    // Switch field: bit 0 zero switch, bit 1 signal switch.
    localparam logic [1:0]  SW_ZEROING   = 2'h1;
    localparam logic [1:0]  SW_SIGNAL    = 2'h2;
    localparam int          TRIM_BITS    = 8;
    // Strobe width of 100 ns at 20 ns period, rounded up.
    localparam int          STROBE_NS    = 100;
    localparam int          CLK_NS       = 20;
    localparam int          STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          SYNC_STAGES  = 3;
endpackage

// [hdl/azc_port_access.sv]
/*
 Single port cycle engine: drives one strobed read or write on the peripheral
 port bus and returns the read byte. Assumes the bus data pins are two-way and
 resolved by the surrounding board logic from the output enable.
*/
`timescale 1ns/1ps
module azc_port_access (
    // Clock and reset.
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Request side.
    input  wire logic       req_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic            done_o,
    output logic [7:0]      rdata_o,
    // Port bus side.
    output logic [7:0]      bus_addr_o,
    output logic [7:0]      bus_d_o,
    output logic            bus_d_oe_o,
    input  wire logic [7:0] bus_d_i,
    output logic            bus_rd_n_o,
    output logic            bus_wr_n_o
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       busy;
    logic       next_busy;
    logic       wr;
    logic       next_wr;
    logic [7:0] addr;
    logic [7:0] next_addr;
    logic [7:0] wdata;
    logic [7:0] next_wdata;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       done;
    logic       next_done;

    // Hold the strobe for the strobe count; read data is caught at its last cycle.
    always_comb begin
        next_cnt   = cnt;
        next_busy  = busy;
        next_wr    = wr;
        next_addr  = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_done  = 1'b0;
        if (!busy && req_i) begin
            next_busy  = 1'b1;
            next_wr    = wr_i;
            next_addr  = addr_i;
            next_wdata = wdata_i;
            next_cnt   = 4'(azc_pkg::STROBE_CYC - 1);
        end else if (busy) begin
            if (cnt == 4'h0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                if (!wr) begin
                    next_rdata = bus_d_i;
                end
            end else begin
                next_cnt = cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt   <= 4'h0;
            busy  <= 1'b0;
            wr    <= 1'b0;
            addr  <= 8'h00;
            wdata <= 8'h00;
            rdata <= 8'h00;
            done  <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            busy  <= next_busy;
            wr    <= next_wr;
            addr  <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            done  <= next_done;
        end
    end

    // Bus pins follow the held request while a cycle runs.
    assign bus_addr_o = addr;
    assign bus_d_o    = wdata;
    assign bus_d_oe_o = busy & wr;
    assign bus_rd_n_o = ~(busy & ~wr);
    assign bus_wr_n_o = ~(busy & wr);
    assign done_o     = done;
    assign rdata_o    = rdata;

    // A finished cycle always follows a busy cycle.
    done_after_busy_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        done |-> $past(busy)) else $error("Port cycle done without a busy cycle.");
endmodule

// [hdl/azc_ctrl.sv]
/*
 Auto-zero offset trim controller. Configures the port bank, closes the zero
 switch, runs an eight-step successive approximation on the trim code using the
 converter result, then switches to the signal path. Assumes inverting buffers on
 every port path and a converter whose completion line is active low.
*/
`timescale 1ns/1ps
module azc_ctrl #(
    parameter int TRIM_W = azc_pkg::TRIM_BITS
) (
    // Clock and reset.
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // User side.
    input  wire logic              start_i,
    output logic                   busy_o,
    output logic                   zeroed_o,
    output logic [TRIM_W-1:0]      trim_o,
    output logic [7:0]             last_result_o,
    output logic [15:0]            handler_addr_o,
    // Converter control.
    output logic                   conv_start_o,
    input  wire logic              conv_done_n_i,
    // Port bus.
    output logic [7:0]             bus_addr_o,
    output logic [7:0]             bus_d_o,
    output logic                   bus_d_oe_o,
    input  wire logic [7:0]        bus_d_i,
    output logic                   bus_rd_n_o,
    output logic                   bus_wr_n_o
);
    typedef enum {
        ST_IDLE, ST_CFG, ST_SW_ZERO, ST_TRIM_CLR, ST_SET_BIT, ST_CONV,
        ST_WAIT, ST_READ, ST_DECIDE, ST_SW_SIG
    } azc_state_e;

    azc_state_e         state;
    azc_state_e         next_state;
    logic [TRIM_W-1:0]  trim;
    logic [TRIM_W-1:0]  next_trim;
    logic [TRIM_W-1:0]  bit_mask;
    logic [TRIM_W-1:0]  next_bit_mask;
    logic [7:0]         result;
    logic [7:0]         next_result;
    logic               zeroed;
    logic               next_zeroed;
    logic               req;
    logic               wr;
    logic [7:0]         addr;
    logic [7:0]         wdata;
    logic               acc_done;
    logic [7:0]         acc_rdata;
    logic [2:0]         sync;
    logic               done_seen;

    // Every port path passes inverting buffers on the board.
    function automatic logic [7:0] inv8(input logic [7:0] v);
        return ~v;
    endfunction

    // Converter done pin: three flops, a change counts when stages two and three agree.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync <= 3'h7;
        end else begin
            sync <= {sync[1:0], conv_done_n_i};
        end
    end
    assign done_seen = ~sync[1] & ~sync[2];

    // Sequencer: each port state issues one port cycle and waits for it to finish; ST_SW_SIG issues two.
    always_comb begin
        next_state    = state;
        next_trim     = trim;
        next_bit_mask = bit_mask;
        next_result   = result;
        next_zeroed   = zeroed;
        req           = 1'b0;
        wr            = 1'b1;
        addr          = azc_pkg::ADDR_CTRL;
        wdata         = 8'h00;
        case (state)
            ST_IDLE: begin
                if (start_i) begin
                    next_zeroed = 1'b0;
                    next_state  = ST_CFG;
                end
            end
            ST_CFG: begin
                req   = 1'b1;
                wdata = inv8(azc_pkg::CTRL_WORD); // see RL7 see RL8 see RL5
                if (acc_done) begin
                    next_state = ST_SW_ZERO;
                end
            end
            ST_SW_ZERO: begin
                req   = 1'b1;
                addr  = azc_pkg::ADDR_SWITCH; // see RL6
                wdata = inv8({6'h00, azc_pkg::SW_ZEROING}); // see RL4 see RL14
                if (acc_done) begin
                    next_trim  = '0; // see RL14
                    next_state = ST_TRIM_CLR;
                end
            end
            ST_TRIM_CLR: begin
                req   = 1'b1;
                addr  = azc_pkg::ADDR_TRIM;
                wdata = inv8(8'(trim));
                if (acc_done) begin
                    next_bit_mask = TRIM_W'(1) << (TRIM_W - 1); // see RL13
                    next_state    = ST_SET_BIT;
                end
            end
            ST_SET_BIT: begin
                // Set the trial bit before its conversion; a one raises the trim node.
                req   = 1'b1;
                addr  = azc_pkg::ADDR_TRIM;
                wdata = inv8(8'(trim | bit_mask)); // see RL13 see RL10 see RL11
                if (acc_done) begin
                    next_trim  = trim | bit_mask;
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                next_state = ST_WAIT; // see RL12
            end
            ST_WAIT: begin
                if (done_seen) begin
                    next_state = ST_READ; // see RL12
                end
            end
            ST_READ: begin
                req  = 1'b1;
                wr   = 1'b0;
                addr = azc_pkg::ADDR_RESULT;
                if (acc_done) begin
                    next_result = inv8(acc_rdata); // see RL5
                    next_state  = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                // A zero result means the output sits negative, since the converter clamps there.
                if (result == 8'h00) begin
                    next_trim = trim & ~bit_mask; // see RL2
                end
                next_bit_mask = bit_mask >> 1;
                if (bit_mask[0]) begin
                    next_state = ST_SW_SIG; // see RL3
                end else begin
                    next_state = ST_SET_BIT;
                end
            end
            ST_SW_SIG: begin
                // Final code goes out first, then the switches swap.
                req   = 1'b1;
                addr  = azc_pkg::ADDR_TRIM;
                wdata = inv8(8'(trim));
                if (zeroed) begin
                    addr  = azc_pkg::ADDR_SWITCH;
                    wdata = inv8({6'h00, azc_pkg::SW_SIGNAL}); // see RL4
                end
                if (acc_done) begin
                    next_zeroed = 1'b1;
                    if (zeroed) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state    <= ST_IDLE;
            trim     <= '0;
            bit_mask <= '0;
            result   <= 8'h00;
            zeroed   <= 1'b0;
        end else begin
            state    <= next_state;
            trim     <= next_trim;
            bit_mask <= next_bit_mask;
            result   <= next_result;
            zeroed   <= next_zeroed;
        end
    end

    // The sequencer drops its request one cycle after done, so req is masked while acc_done is high.
    azc_port_access u_port (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .req_i      (req & ~acc_done),
        .wr_i       (wr),
        .addr_i     (addr),
        .wdata_i    (wdata),
        .done_o     (acc_done),
        .rdata_o    (acc_rdata),
        .bus_addr_o (bus_addr_o),
        .bus_d_o    (bus_d_o),
        .bus_d_oe_o (bus_d_oe_o),
        .bus_d_i    (bus_d_i),
        .bus_rd_n_o (bus_rd_n_o),
        .bus_wr_n_o (bus_wr_n_o)
    );

    // User outputs; zeroed holds once the signal switch has closed.
    assign busy_o         = (state != ST_IDLE);
    assign zeroed_o       = zeroed & (state == ST_IDLE);
    assign trim_o         = trim;
    assign last_result_o  = result;
    assign handler_addr_o = azc_pkg::HANDLER_ADDR; // see RL9
    assign conv_start_o   = (state == ST_CONV);

    // Exactly eight decide steps between the trim clear and the signal switch.
    logic [3:0] steps;
    logic [3:0] next_steps;
    always_comb begin
        next_steps = steps;
        if (state == ST_TRIM_CLR) begin
            next_steps = 4'h0;
        end else if (state == ST_DECIDE) begin
            next_steps = steps + 4'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            steps <= 4'h0;
        end else begin
            steps <= next_steps;
        end
    end

    // One measurement step: the start pulse, then a wait that only the synchronised done line ends.
    sequence conv_pulse_s;
        conv_start_o;
    endsequence
    sequence wait_entered_s;
        state == ST_WAIT;
    endsequence

    step_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL3
        (state == ST_SW_SIG && $past(state) == ST_DECIDE) |-> steps == 4'(TRIM_W))
        else $error("Search did not take eight steps.");
    zero_clears_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL2
        (state == ST_DECIDE && result == 8'h00) |=> (trim & $past(bit_mask)) == '0)
        else $error("Trial bit not cleared on zero result.");
    nonzero_keeps_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL2
        (state == ST_DECIDE && result != 8'h00) |=> (trim & $past(bit_mask)) != '0)
        else $error("Trial bit dropped on nonzero result.");
    read_after_done_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL12
        (state == ST_READ && $past(state) == ST_WAIT) |-> $past(done_seen))
        else $error("Result read before completion.");
    start_then_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL12
        conv_pulse_s |=> wait_entered_s) else $error("Start not followed by wait.");
    bit_set_before_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL13
        conv_start_o |-> (trim & bit_mask) == bit_mask) else $error("Trial bit not set.");
    trim_cleared_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL14
        (state == ST_TRIM_CLR) |-> trim == '0) else $error("Trim not cleared before search.");
    result_inverted_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL5
        (state == ST_READ && acc_done) |=> result == ~$past(acc_rdata))
        else $error("Result not inverted.");
endmodule

// [verif/azc_dev_model.sv]
/*
 Behavioural model of the far side: port bank behind inverting buffers, the
 converter with an active-low completion line, the input switches and the trim
 ladder. Assumes the controller holds address and data steady through each strobe.
*/
`timescale 1ns/1ps
module azc_dev_model (
    // Clock and reset.
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Scenario knobs.
    input  wire logic [8:0] offset_i,
    input  wire logic [7:0] conv_cyc_i,
    // Port bus and converter.
    input  wire logic [7:0] bus_addr_i,
    input  wire logic [7:0] bus_d_i,
    input  wire logic       bus_d_oe_i,
    input  wire logic       bus_rd_n_i,
    input  wire logic       bus_wr_n_i,
    input  wire logic       conv_start_i,
    output logic [7:0]      bus_q_o,
    output logic            conv_done_n_o,
    // Observation.
    output logic [7:0]      trim_q_o,
    output logic [7:0]      sw_q_o,
    output logic [7:0]      ctrl_q_o,
    output logic [3:0]      conv_cnt_o,
    output logic [3:0]      fault_o,
    output logic [7:0]      trial_o [8]
);
    logic [7:0] result;
    logic [7:0] wait_cnt;
    logic       conv_busy;
    logic       rd_prev;
    logic [8:0] diff;

    // Ladder: a set trim bit lowers the preamp output by its binary weight.
    assign diff = offset_i - {1'b0, trim_q_o};

    // Port latches, converter timing and read-back, all on the system clock.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            conv_done_n_o <= 1'b1;
            conv_busy     <= 1'b0;
            conv_cnt_o    <= 4'h0;
            fault_o       <= 4'h0;
            rd_prev       <= 1'b1;
        end else begin
            rd_prev <= bus_rd_n_i;
            if (!bus_wr_n_i && bus_d_oe_i) begin
                case (bus_addr_i)
                    azc_pkg::ADDR_TRIM:   trim_q_o <= ~bus_d_i;
                    azc_pkg::ADDR_SWITCH: sw_q_o   <= ~bus_d_i;
                    azc_pkg::ADDR_CTRL: begin
                        ctrl_q_o   <= ~bus_d_i;
                        conv_cnt_o <= 4'h0;
                    end
                    default: ;
                endcase
            end
            if (conv_start_i) begin
                conv_busy <= 1'b1;
                wait_cnt  <= conv_cyc_i;
                // A negative preamp output converts to all zeros.
                result    <= (offset_i <= {1'b0, trim_q_o}) ? 8'h00 : (diff > 9'h0FF ? 8'hFF : diff[7:0]);
                if (conv_cnt_o < 4'h8) begin
                    trial_o[conv_cnt_o[2:0]] <= trim_q_o;
                end
                conv_cnt_o <= conv_cnt_o + 4'h1;
                if (sw_q_o !== {6'h00, azc_pkg::SW_ZEROING}) begin
                    fault_o <= fault_o + 4'h1;
                end
            end else if (conv_busy) begin
                if (wait_cnt == 8'h00) begin
                    conv_busy     <= 1'b0;
                    conv_done_n_o <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt - 8'h01;
                end
            end
            // Completion is cleared by the read; a read before completion is a fault.
            if (!bus_rd_n_i && rd_prev && bus_addr_i == azc_pkg::ADDR_RESULT) begin
                conv_done_n_o <= 1'b1;
                if (conv_done_n_o) begin
                    fault_o <= fault_o + 4'h1;
                end
            end
        end
        // Released data lines toggle so a stale value can never pass.
        if (!bus_rd_n_i && bus_addr_i == azc_pkg::ADDR_RESULT) begin
            bus_q_o <= ~result;
        end else begin
            bus_q_o <= ~bus_q_o;
        end
    end
endmodule

// [verif/auto_zero_offset_trim_controller_test.sv]
/*
 Self-checking testbench for the auto-zero controller against the device model.
 Assumes a 50 MHz clock and a synchronous active-low reset held eight cycles.
*/
`timescale 1ns/1ps
module auto_zero_offset_trim_controller_test;
    logic        mclk_i, rst_n_i, start_i, busy_o, zeroed_o, conv_start_o, conv_done_n_i;
    logic [7:0]  trim_o, last_result_o, bus_addr_o, bus_d_o, bus_d_i, trim_q, sw_q, ctrl_q;
    logic [15:0] handler_addr_o;
    logic        bus_d_oe_o, bus_rd_n_o, bus_wr_n_o;
    logic [8:0]  offset;
    logic [7:0]  conv_cyc;
    logic [3:0]  conv_cnt, fault;
    logic [7:0]  trial [8];
    int          err_count, checks;

    azc_ctrl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i), .busy_o(busy_o),
        .zeroed_o(zeroed_o), .trim_o(trim_o), .last_result_o(last_result_o),
        .handler_addr_o(handler_addr_o), .conv_start_o(conv_start_o), .conv_done_n_i(conv_done_n_i),
        .bus_addr_o(bus_addr_o), .bus_d_o(bus_d_o), .bus_d_oe_o(bus_d_oe_o), .bus_d_i(bus_d_i),
        .bus_rd_n_o(bus_rd_n_o), .bus_wr_n_o(bus_wr_n_o));

    azc_dev_model model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .offset_i(offset), .conv_cyc_i(conv_cyc),
        .bus_addr_i(bus_addr_o), .bus_d_i(bus_d_o), .bus_d_oe_i(bus_d_oe_o), .bus_rd_n_i(bus_rd_n_o),
        .bus_wr_n_i(bus_wr_n_o), .conv_start_i(conv_start_o), .bus_q_o(bus_d_i),
        .conv_done_n_o(conv_done_n_i), .trim_q_o(trim_q), .sw_q_o(sw_q), .ctrl_q_o(ctrl_q),
        .conv_cnt_o(conv_cnt), .fault_o(fault), .trial_o(trial));

    // Free-running system clock.
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Converter reading for a given offset and trim, worked out independently.
    function automatic logic [7:0] reading(input logic [8:0] off, input logic [7:0] t);
        if (off <= {1'b0, t}) return 8'h00;
        return (off - t > 9'h0FF) ? 8'hFF : 8'(off - t);
    endfunction

    // Raises start for one cycle and confirms the run is taken.
    task automatic kick();
        @(posedge mclk_i) start_i <= 1'b1;
        @(posedge mclk_i) start_i <= 1'b0;
        @(negedge mclk_i) chk(16'(busy_o), 16'h0001);
    endtask

    // Runs a full search; a second start in mid-run must be ignored.
    task automatic run_search(input logic [8:0] off, input logic [7:0] cyc, input bit poke);
        logic [7:0] t, tr, r;
        int i;
        t = 8'h00;
        r = 8'h00;
        offset   <= off;
        conv_cyc <= cyc;
        kick();
        if (poke) begin
            repeat (60) @(negedge mclk_i);
            kick();
        end
        for (i = 0; i < 4000; i++) begin
            @(negedge mclk_i);
            if (zeroed_o === 1'b1) break;
        end
        chk(16'(zeroed_o), 16'h0001);
        chk(16'(busy_o), 16'h0000);
        for (i = 0; i < 8; i++) begin
            tr = t | (8'h80 >> i);
            chk(16'(trial[i]), 16'(tr));
            r = reading(off, tr);
            if (r != 8'h00) t = tr;
        end
        chk(16'(trim_o), 16'(t));
        chk(16'(trim_q), 16'(t));
        chk(16'(last_result_o), 16'(r));
        chk(16'(conv_cnt), 16'h0008);
        chk(16'(fault), 16'h0000);
        chk(16'(sw_q), {14'h0000, azc_pkg::SW_SIGNAL});
        chk(16'(ctrl_q), 16'(azc_pkg::CTRL_WORD));
        chk({13'h0000, bus_rd_n_o, bus_wr_n_o, bus_d_oe_o}, 16'h0006);
    endtask

    // Idle state straight after reset, and the fixed handler address.
    task automatic t_after_reset();
        @(negedge mclk_i);
        chk({12'h000, busy_o, zeroed_o, conv_start_o, bus_d_oe_o}, 16'h0000);
        chk(16'(trim_o), 16'h0000);
        chk(handler_addr_o, 16'h3C3D);
    endtask

    // Zero offset: every reading is zero, so every trial bit is cleared.
    task automatic t_zero_offset();
        run_search(9'h000, 8'd3, 1'b0);
    endtask

    // Offset beyond the ladder range keeps every trial bit.
    task automatic t_full_scale();
        run_search(9'h12C, 8'd0, 1'b0);
    endtask

    // Mid offset with a slow converter and a refused second start.
    task automatic t_slow_refused();
        run_search(9'h05A, 8'd40, 1'b1);
    endtask

    // Reset in mid-run returns everything to idle, then a run still works.
    task automatic t_reset_midrun();
        offset <= 9'h0C3;
        kick();
        repeat (40) @(negedge mclk_i);
        @(posedge mclk_i) rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        chk({12'h000, busy_o, zeroed_o, conv_start_o, bus_d_oe_o}, 16'h0000);
        chk({8'h00, trim_o}, 16'h0000);
        chk({14'h0000, bus_rd_n_o, bus_wr_n_o}, 16'h0003);
        @(posedge mclk_i) rst_n_i <= 1'b1;
        run_search(9'h081, 8'd0, 1'b0);
    endtask

    // Main sequence.
    initial begin
        err_count = 0;
        checks    = 0;
        rst_n_i   = 1'b0;
        start_i   = 1'b0;
        offset    = 9'h000;
        conv_cyc  = 8'd2;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_after_reset();
        t_zero_offset();
        t_full_scale();
        t_slow_refused();
        t_reset_midrun();
        close_out();
    end

    // Watchdog: the whole run needs a few thousand cycles at most.
    initial begin
        repeat (40000) @(posedge mclk_i);
        err_count++;
        close_out();
    end
endmodule
